/* File: pkg/ladder_pkg.sv */
package ladder_pkg;
   localparam int unsigned CLK_NS = 40;
   localparam int unsigned MS_NS = 1000000;
   localparam int unsigned MS_CYCLES = MS_NS / CLK_NS;
   localparam int unsigned FINE_STEP_MS = 10;
   localparam logic [3:0] DEC_LAST = 4'(FINE_STEP_MS - 1);
   localparam int NUM_TIMERS = 5;
   localparam int NUM_PAIRS = 7;
   localparam int TBL_WORDS = 16;
   localparam logic [13:0] CNT_TERM_ZERO = 14'h2710;
   // byte offsets
   localparam logic [7:0] A_CMD = 8'h00;
   localparam logic [7:0] A_OPA = 8'h04;
   localparam logic [7:0] A_OPB = 8'h08;
   localparam logic [7:0] A_RES = 8'h0C;
   localparam logic [7:0] A_FLAGS = 8'h10;
   localparam logic [7:0] A_TCTL = 8'h14;
   localparam logic [7:0] A_STAT = 8'h18;
   localparam logic [7:0] A_FINE_PRE = 8'h1C;
   localparam logic [7:0] A_MS_PRE = 8'h20;
   localparam logic [7:0] A_CCTL = 8'h24;
   localparam logic [7:0] A_CNT_PRE = 8'h28;
   localparam logic [7:0] A_CNT_PV = 8'h2C;
   localparam logic [7:0] A_SHIFT = 8'h30;
   localparam logic [1:0] TBL_PAGE = 2'h1;
   // fields
   localparam int F_ER = 0;
   localparam int F_CY = 1;
   localparam int F_LT = 2;
   localparam int F_EQ = 3;
   localparam int F_GT = 4;
   localparam int FLAG_LSB = 11;
   localparam int C_A = 8;
   localparam int C_B = 9;
   localparam int C_C = 10;
   localparam int RD_ONE_LSB = 8;
   localparam int RD_TWO_LSB = 12;
   localparam int ST_KEEP = 8;
   localparam int ST_CNT = 9;
   localparam int CC_START = 0;
   localparam int CC_RESET = 1;
   localparam logic [1:0] RD_SEC = 2'h0;
   localparam logic [1:0] RD_TENTH = 2'h1;
   // command codes
   localparam logic [7:0] OP_END = 8'h01;
   localparam logic [7:0] OP_KEEP = 8'h0C;
   localparam logic [7:0] OP_DRUM = 8'h17;
   localparam logic [7:0] OP_MOV = 8'h1E;
   localparam logic [7:0] OP_MVN = 8'h1F;
   localparam logic [7:0] OP_CMP = 8'h20;
   localparam logic [7:0] OP_SFT = 8'h21;
   localparam logic [7:0] OP_BCMP = 8'h22;
   localparam logic [7:0] OP_ADD = 8'h28;
   localparam logic [7:0] OP_SUB = 8'h29;
   localparam logic [7:0] OP_AND = 8'h2A;
   localparam logic [7:0] OP_OR = 8'h2B;
   localparam logic [7:0] OP_CLC = 8'h2C;

   function automatic logic bcd_ok(input logic [15:0] v);
      logic ok;
      ok = 1'b1;
      for (int i = 0; i < 4; i++) begin
         if (v[4*i +: 4] > 4'h9) ok = 1'b0;
      end
      return ok;
   endfunction

   function automatic logic [16:0] bcd_add(input logic [15:0] a,
                                           input logic [15:0] b,
                                           input logic cin);
      logic [4:0] s;
      logic c;
      logic [15:0] r;
      c = cin;
      r = 16'h0000;
      for (int i = 0; i < 4; i++) begin
         s = {1'b0, a[4*i +: 4]} + {1'b0, b[4*i +: 4]} + {4'h0, c};
         c = (s > 5'h09);
         if (c) s = s + 5'h06;
         r[4*i +: 4] = s[3:0];
      end
      return {c, r};
   endfunction

   function automatic logic [16:0] bcd_sub(input logic [15:0] a,
                                           input logic [15:0] b,
                                           input logic bin);
      logic [4:0] t;
      logic c;
      logic [15:0] r;
      c = bin;
      r = 16'h0000;
      for (int i = 0; i < 4; i++) begin
         t = {1'b0, a[4*i +: 4]} + 5'h0A - {1'b0, b[4*i +: 4]} - {4'h0, c};
         c = (t < 5'h0A);
         if (!c) t = t - 5'h0A;
         r[4*i +: 4] = t[3:0];
      end
      return {c, r};
   endfunction

   function automatic logic [13:0] bcd2bin(input logic [15:0] v);
      return 14'(v[15:12]) * 14'h03E8 + 14'(v[11:8]) * 14'h0064
           + 14'(v[7:4]) * 14'h000A + 14'(v[3:0]);
   endfunction
endpackage

/* File: core/ladder_special_arith_exec.sv */
`timescale 1ns/1ps
`default_nettype none
module ladder_special_arith_exec #(
   parameter int unsigned MS_CYCLES = ladder_pkg::MS_CYCLES
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic count_pulse,
   input wire logic [7:0] panel_adj_a,
   input wire logic [7:0] panel_adj_b,
   input wire logic [7:0] panel_adj_c,
   output logic keep_bit,
   output logic count_done,
   output logic [4:0] timer_done
);
   // ************************************************************
   // bus slave
   // ************************************************************
   logic [7:0] addr_q;
   logic wr_q, rd_q, hready_q;
   logic [31:0] hrdata_q;
   logic [31:0] rd_mux;
   wire take = hsel & hready & htrans[1];

   // reads take one wait state so a write just before is seen
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         addr_q <= 8'h00;
         wr_q <= 1'b0;
         rd_q <= 1'b0;
         hready_q <= 1'b1;
         hrdata_q <= 32'h0000_0000;
      end else begin
         if (take) addr_q <= haddr[7:0];
         wr_q <= take & hwrite;
         rd_q <= take & ~hwrite;
         hready_q <= ~(take & ~hwrite);
         if (rd_q) hrdata_q <= rd_mux;
      end
   end
   assign hrdata = hrdata_q;
   assign hreadyout = hready_q;
   assign hresp = 1'b0;

   wire [15:0] wdata = hwdata[15:0];
   wire we_cmd = wr_q && addr_q == ladder_pkg::A_CMD;
   wire we_opa = wr_q && addr_q == ladder_pkg::A_OPA;
   wire we_opb = wr_q && addr_q == ladder_pkg::A_OPB;
   wire we_flags = wr_q && addr_q == ladder_pkg::A_FLAGS;
   wire we_tctl = wr_q && addr_q == ladder_pkg::A_TCTL;
   wire we_fine = wr_q && addr_q == ladder_pkg::A_FINE_PRE;
   wire we_ms = wr_q && addr_q == ladder_pkg::A_MS_PRE;
   wire we_cctl = wr_q && addr_q == ladder_pkg::A_CCTL;
   wire we_cpre = wr_q && addr_q == ladder_pkg::A_CNT_PRE;
   wire we_tbl = wr_q && addr_q[7:6] == ladder_pkg::TBL_PAGE;
   wire [3:0] tbl_idx = addr_q[5:2];

   // ************************************************************
   // software registers
   // ************************************************************
   logic [15:0] opa_q, opb_q, tctl_q, fine_pre_q, ms_pre_q, cctl_q;
   logic [15:0] cnt_pre_q;
   logic [15:0] tbl_q [ladder_pkg::TBL_WORDS];

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         opa_q <= 16'h0000;
         opb_q <= 16'h0000;
         tctl_q <= 16'h0000;
         fine_pre_q <= 16'h0000;
         ms_pre_q <= 16'h0000;
         cctl_q <= 16'h0000;
         cnt_pre_q <= 16'h0000;
         for (int i = 0; i < ladder_pkg::TBL_WORDS; i++) begin
            tbl_q[i] <= 16'h0000;
         end
      end else begin
         if (we_opa) opa_q <= wdata;
         if (we_opb) opb_q <= wdata;
         if (we_tctl) tctl_q <= wdata;
         if (we_fine) fine_pre_q <= wdata;
         if (we_ms) ms_pre_q <= wdata;
         if (we_cctl) cctl_q <= wdata;
         if (we_cpre) cnt_pre_q <= wdata;
         if (we_tbl) tbl_q[tbl_idx] <= wdata;
      end
   end

   // ************************************************************
   // time bases
   // ************************************************************
   logic [15:0] ms_cnt_q;
   logic [3:0] d10_q, d100_q, d1s_q;
   wire tick_ms = ms_cnt_q == 16'(MS_CYCLES - 1);
   wire tick_10 = tick_ms && d10_q == ladder_pkg::DEC_LAST;
   wire tick_100 = tick_10 && d100_q == ladder_pkg::DEC_LAST;
   wire tick_1s = tick_100 && d1s_q == ladder_pkg::DEC_LAST;

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         ms_cnt_q <= 16'h0000;
         d10_q <= 4'h0;
         d100_q <= 4'h0;
         d1s_q <= 4'h0;
      end else begin
         ms_cnt_q <= tick_ms ? 16'h0000 : ms_cnt_q + 16'h0001;
         if (tick_ms) d10_q <= tick_10 ? 4'h0 : d10_q + 4'h1;
         if (tick_10) d100_q <= tick_100 ? 4'h0 : d100_q + 4'h1;
         if (tick_100) d1s_q <= tick_1s ? 4'h0 : d1s_q + 4'h1;
      end
   end

   // ************************************************************
   // decrementing timers
   // ************************************************************
   wire [1:0] rd_one = tctl_q[ladder_pkg::RD_ONE_LSB +: 2];
   wire [1:0] rd_two = tctl_q[ladder_pkg::RD_TWO_LSB +: 2];
   // unknown range codes fall to the finest step
   wire tick_one = rd_one == ladder_pkg::RD_SEC ? tick_1s :
                   rd_one == ladder_pkg::RD_TENTH ? tick_100 : tick_10;
   wire tick_two = rd_two == ladder_pkg::RD_SEC ? tick_1s :
                   rd_two == ladder_pkg::RD_TENTH ? tick_100 : tick_10;
   wire [4:0][13:0] tpre;
   wire [4:0] ttick;
   assign tpre[0] = ladder_pkg::bcd2bin(fine_pre_q);
   assign ttick[0] = tick_10;
   assign tpre[1] = ladder_pkg::bcd2bin(ms_pre_q);
   assign ttick[1] = tick_ms;
   assign tpre[2] = {6'h00, panel_adj_a};
   assign ttick[2] = tick_100;
   assign tpre[3] = {6'h00, panel_adj_b};
   assign ttick[3] = tick_one;
   assign tpre[4] = {6'h00, panel_adj_c};
   assign ttick[4] = tick_two;

   logic [13:0] tcnt_q [ladder_pkg::NUM_TIMERS];
   logic [4:0] ten_prev_q, tdone_q;
   wire [4:0] ten = tctl_q[4:0];

   for (genvar i = 0; i < ladder_pkg::NUM_TIMERS; i++) begin : g_tim
      // preset is taken at the start edge; later changes wait for a restart
      always_ff @(posedge ref_clk or negedge rst_n) begin
         if (!rst_n) begin
            tcnt_q[i] <= 14'h0000;
            ten_prev_q[i] <= 1'b0;
            tdone_q[i] <= 1'b0;
         end else begin
            ten_prev_q[i] <= ten[i];
            if (!ten[i]) begin
               tcnt_q[i] <= 14'h0000;
               tdone_q[i] <= 1'b0;
            end else if (!ten_prev_q[i]) begin
               tcnt_q[i] <= tpre[i];
               tdone_q[i] <= tpre[i] == 14'h0000;
            end else if (ttick[i] && tcnt_q[i] != 14'h0000) begin
               tcnt_q[i] <= tcnt_q[i] - 14'h0001;
               if (tcnt_q[i] == 14'h0001) tdone_q[i] <= 1'b1;
            end
         end
      end
      a_timer_done: assert property (@(posedge ref_clk) disable iff (!rst_n)
         ten[i] && ten_prev_q[i] && ttick[i] && tcnt_q[i] == 14'h0001
         |=> tdone_q[i] && tcnt_q[i] == 14'h0000)
         else $error("timer did not complete at zero");
   end
   assign timer_done = tdone_q;

   // ************************************************************
   // fast pulse counter
   // ************************************************************
   logic [13:0] pv_q;
   logic cp_prev_q, cnt_done_q;
   wire cnt_start = cctl_q[ladder_pkg::CC_START];
   wire cnt_reset = cctl_q[ladder_pkg::CC_RESET];
   wire cp_rise = count_pulse & ~cp_prev_q;
   wire pre_ok = ladder_pkg::bcd_ok(cnt_pre_q);
   wire [13:0] cnt_term = cnt_pre_q == 16'h0000 ? ladder_pkg::CNT_TERM_ZERO
                          : ladder_pkg::bcd2bin(cnt_pre_q);
   wire cnt_step = cp_rise & cnt_start & ~cnt_reset;
   wire cnt_hit = cnt_step & pre_ok & (pv_q + 14'h0001 == cnt_term);
   wire cnt_bad = cnt_step & ~pre_ok;
   logic [7:0] op;
   logic exec_stb, end_stb;
   assign op = hwdata[7:0];
   assign exec_stb = we_cmd;
   assign end_stb = exec_stb && op == ladder_pkg::OP_END;

   // a scan ends with the end command; done spans up to that boundary
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         pv_q <= 14'h0000;
         cp_prev_q <= 1'b0;
         cnt_done_q <= 1'b0;
      end else begin
         cp_prev_q <= count_pulse;
         if (cnt_reset || cnt_hit) pv_q <= 14'h0000;
         else if (cnt_step && pre_ok) pv_q <= pv_q + 14'h0001;
         if (cnt_hit) cnt_done_q <= 1'b1;
         else if (end_stb) cnt_done_q <= 1'b0;
      end
   end
   assign count_done = cnt_done_q;

   a_cnt_wrap: assert property (@(posedge ref_clk) disable iff (!rst_n)
      cnt_hit |=> pv_q == 14'h0000 && cnt_done_q)
      else $error("counter did not wrap with done");
   a_cnt_held: assert property (@(posedge ref_clk) disable iff (!rst_n)
      cnt_reset && !cnt_hit |=> pv_q == 14'h0000)
      else $error("counter moved while reset");

   // ************************************************************
   // range tables
   // ************************************************************
   wire [13:0] drum_size = ladder_pkg::bcd2bin(tbl_q[0]);
   wire [3:0] blk_n = tbl_q[0][3:0];
   wire [15:0] drum_hit, blk_hit;
   assign drum_hit[15:ladder_pkg::NUM_PAIRS] = '0;
   assign blk_hit[15:ladder_pkg::NUM_PAIRS] = '0;
   for (genvar i = 0; i < ladder_pkg::NUM_PAIRS; i++) begin : g_rng
      wire in_r = opa_q >= tbl_q[2*i+1] && opa_q <= tbl_q[2*i+2];
      assign drum_hit[i] = in_r && 14'(i) < drum_size;
      assign blk_hit[i] = in_r && 4'(i) <= blk_n;
   end
   wire drum_bad = !ladder_pkg::bcd_ok(tbl_q[0])
                   || drum_size > 14'(ladder_pkg::NUM_PAIRS);
   wire blk_bad = blk_n > 4'(ladder_pkg::NUM_PAIRS - 1);

   // ************************************************************
   // instruction execution
   // ************************************************************
   logic [15:0] res_q, res_d, shift_q, shift_d;
   logic [4:0] flags_q, flags_d;
   logic sp_q, sp_d, keep_q, keep_d;
   wire ca = hwdata[ladder_pkg::C_A];
   wire cb = hwdata[ladder_pkg::C_B];
   wire cc = hwdata[ladder_pkg::C_C];
   wire free_op = op == ladder_pkg::OP_END || op == ladder_pkg::OP_KEEP
                  || op == ladder_pkg::OP_CLC;
   wire skip = flags_q[ladder_pkg::F_ER] && !free_op;
   wire ops_bcd = ladder_pkg::bcd_ok(opa_q) && ladder_pkg::bcd_ok(opb_q);
   wire [16:0] add_w = ladder_pkg::bcd_add(opa_q, opb_q,
                                           flags_q[ladder_pkg::F_CY]);
   wire [16:0] sub_w = ladder_pkg::bcd_sub(opa_q, opb_q,
                                           flags_q[ladder_pkg::F_CY]);

   always_comb begin
      res_d = res_q;
      flags_d = flags_q;
      shift_d = shift_q;
      sp_d = sp_q;
      keep_d = keep_q;
      if (exec_stb && !skip) begin
         unique case (op)
            ladder_pkg::OP_END: flags_d = 5'h00;
            ladder_pkg::OP_KEEP: begin
               if (cb) keep_d = 1'b0;
               else if (ca) keep_d = 1'b1;
            end
            ladder_pkg::OP_DRUM: begin
               if (drum_bad) flags_d[ladder_pkg::F_ER] = 1'b1;
               else res_d = drum_hit;
            end
            ladder_pkg::OP_MOV: begin
               res_d = opa_q;
               flags_d[ladder_pkg::F_EQ] = opa_q == 16'h0000;
            end
            ladder_pkg::OP_MVN: begin
               res_d = ~opa_q;
               flags_d[ladder_pkg::F_EQ] = opa_q == 16'hFFFF;
            end
            ladder_pkg::OP_CMP: begin
               flags_d[ladder_pkg::F_LT] = opa_q < opb_q;
               flags_d[ladder_pkg::F_EQ] = opa_q == opb_q;
               flags_d[ladder_pkg::F_GT] = opa_q > opb_q;
            end
            ladder_pkg::OP_SFT: begin
               sp_d = cb;
               if (cc) shift_d = 16'h0000;
               else if (cb && !sp_q) shift_d = {shift_q[14:0], ca};
            end
            ladder_pkg::OP_BCMP: begin
               if (blk_bad) flags_d[ladder_pkg::F_ER] = 1'b1;
               else res_d = blk_hit;
            end
            ladder_pkg::OP_ADD: begin
               if (!ops_bcd) flags_d[ladder_pkg::F_ER] = 1'b1;
               else begin
                  {flags_d[ladder_pkg::F_CY], res_d} = add_w;
                  flags_d[ladder_pkg::F_EQ] = add_w[15:0] == 16'h0000;
               end
            end
            ladder_pkg::OP_SUB: begin
               if (!ops_bcd) flags_d[ladder_pkg::F_ER] = 1'b1;
               else begin
                  {flags_d[ladder_pkg::F_CY], res_d} = sub_w;
                  flags_d[ladder_pkg::F_EQ] = sub_w[15:0] == 16'h0000;
               end
            end
            ladder_pkg::OP_AND: begin
               res_d = opa_q & opb_q;
               flags_d[ladder_pkg::F_EQ] = (opa_q & opb_q) == 16'h0000;
            end
            ladder_pkg::OP_OR: begin
               res_d = opa_q | opb_q;
               flags_d[ladder_pkg::F_EQ] = (opa_q | opb_q) == 16'h0000;
            end
            ladder_pkg::OP_CLC: flags_d[ladder_pkg::F_CY] = 1'b0;
            default: ;
         endcase
      end
      if (we_flags) flags_d = wdata[ladder_pkg::FLAG_LSB +: 5];
      // a counter fault wins over a software clear in the same cycle
      if (cnt_bad) flags_d[ladder_pkg::F_ER] = 1'b1;
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         res_q <= 16'h0000;
         shift_q <= 16'h0000;
         flags_q <= 5'h00;
         sp_q <= 1'b0;
         keep_q <= 1'b0;
      end else begin
         res_q <= res_d;
         shift_q <= shift_d;
         flags_q <= flags_d;
         sp_q <= sp_d;
         keep_q <= keep_d;
      end
   end
   assign keep_bit = keep_q;

   a_keep_reset: assert property (@(posedge ref_clk) disable iff (!rst_n)
      exec_stb && op == ladder_pkg::OP_KEEP && cb |=> !keep_q)
      else $error("latch not cleared by reset input");
   a_cmp_onehot: assert property (@(posedge ref_clk) disable iff (!rst_n)
      exec_stb && op == ladder_pkg::OP_CMP && !skip
      |=> $onehot(flags_q[4:2]))
      else $error("compare flags not one-hot");
   a_bad_bcd: assert property (@(posedge ref_clk) disable iff (!rst_n)
      exec_stb && op == ladder_pkg::OP_ADD && !skip && !ops_bcd
      |=> flags_q[ladder_pkg::F_ER] && $stable(res_q))
      else $error("bad BCD operand written");
   a_er_skip: assert property (@(posedge ref_clk) disable iff (!rst_n)
      exec_stb && flags_q[ladder_pkg::F_ER] && op == ladder_pkg::OP_MOV
      |=> $stable(res_q))
      else $error("instruction ran with error flag on");
   a_mov_eq: assert property (@(posedge ref_clk) disable iff (!rst_n)
      exec_stb && op == ladder_pkg::OP_MOV && !skip
      |=> flags_q[ladder_pkg::F_EQ] == (res_q == 16'h0000))
      else $error("equals flag wrong after copy");
   a_clc_zero: assert property (@(posedge ref_clk) disable iff (!rst_n)
      exec_stb && op == ladder_pkg::OP_CLC && !cnt_bad
      |=> !flags_q[ladder_pkg::F_CY])
      else $error("carry not cleared");
   a_read_wait: assert property (@(posedge ref_clk) disable iff (!rst_n)
      take && !hwrite |=> !hreadyout ##1 hreadyout)
      else $error("read wait state wrong");

   // ************************************************************
   // read-back
   // ************************************************************
   wire [15:0] stat_w = {6'h00, cnt_done_q, keep_q, 3'h0, tdone_q};
   assign rd_mux =
      addr_q[7:6] == ladder_pkg::TBL_PAGE ? {16'h0000, tbl_q[tbl_idx]} :
      addr_q == ladder_pkg::A_OPA ? {16'h0000, opa_q} :
      addr_q == ladder_pkg::A_OPB ? {16'h0000, opb_q} :
      addr_q == ladder_pkg::A_RES ? {16'h0000, res_q} :
      addr_q == ladder_pkg::A_FLAGS ? {16'h0000, flags_q, 11'h000} :
      addr_q == ladder_pkg::A_TCTL ? {16'h0000, tctl_q} :
      addr_q == ladder_pkg::A_STAT ? {16'h0000, stat_w} :
      addr_q == ladder_pkg::A_FINE_PRE ? {16'h0000, fine_pre_q} :
      addr_q == ladder_pkg::A_MS_PRE ? {16'h0000, ms_pre_q} :
      addr_q == ladder_pkg::A_CCTL ? {16'h0000, cctl_q} :
      addr_q == ladder_pkg::A_CNT_PRE ? {16'h0000, cnt_pre_q} :
      addr_q == ladder_pkg::A_CNT_PV ? {18'h00000, pv_q} :
      addr_q == ladder_pkg::A_SHIFT ? {16'h0000, shift_q} : 32'h0000_0000;
endmodule
`default_nettype wire

/* File: tb/pulse_src.sv */
`timescale 1ns/1ps
`default_nettype none
module pulse_src (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic run,
   output logic count_pulse,
   output logic [7:0] adj_a,
   output logic [7:0] adj_b,
   output logic [7:0] adj_c
);
   logic [1:0] ph_q;
   // fixed front-panel settings, kept small so every timer ends in the run
   assign adj_a = 8'h05;
   assign adj_b = 8'h0A;
   assign adj_c = 8'h03;
   // pulse high two clocks in four, so every edge is seen
   assign count_pulse = run & ph_q[1];
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) ph_q <= 2'h0;
      else ph_q <= ph_q + 2'h1;
   end
endmodule
`default_nettype wire

/* File: tb/ladder_special_arith_exec_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module ladder_special_arith_exec_tb_top;
   logic ref_clk, rst_n, hsel, hwrite, run, cp, cp_q, kb, cd, rdy, hresp;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [31:0] haddr, hwdata, hrdata, q;
   logic [7:0] pa, pb, pc;
   logic [4:0] td;
   logic [15:0] r, a, b;
   int num_errors, cmp_count, n, edges;
   pulse_src PS (.ref_clk(ref_clk), .rst_n(rst_n), .run(run),
      .count_pulse(cp), .adj_a(pa), .adj_b(pb), .adj_c(pc));
   ladder_special_arith_exec #(.MS_CYCLES(4)) DUT (.ref_clk(ref_clk),
      .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(rdy),
      .hrdata(hrdata), .hreadyout(rdy), .hresp(hresp), .count_pulse(cp),
      .panel_adj_a(pa), .panel_adj_b(pb), .panel_adj_c(pc),
      .keep_bit(kb), .count_done(cd), .timer_done(td));
   initial begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end
   function automatic logic [15:0] lfsr(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction
   task automatic stop_test();
      $display("errors %0d compares %0d", num_errors, cmp_count);
      if (num_errors == 0 && cmp_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] s);
      cmp_count++;
      if (s !== e) begin
         $display("mismatch %s exp %h got %h", nm, e, s);
         num_errors++;
      end
   endtask
   // one single-word transfer; waits are bounded, a hang ends the run
   task automatic bus(input logic w, input logic [7:0] ad,
                      input logic [31:0] d);
      @(posedge ref_clk);
      hsel <= 1'b1; htrans <= 2'h2; hwrite <= w; haddr <= {24'h0, ad};
      n = 0;
      do begin @(posedge ref_clk); n++; end while (rdy !== 1'b1 && n < 50);
      if (n >= 50) begin num_errors++; stop_test(); end
      hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
      do begin @(posedge ref_clk); n++; end while (rdy !== 1'b1 && n < 99);
      q = hrdata;
      if (n >= 99) begin num_errors++; stop_test(); end
   endtask
   task automatic op(input logic [2:0] c, input logic [7:0] code);
      bus(1'b1, ladder_pkg::A_CMD, {21'h0, c, code});
   endtask
   task automatic rd(input logic [7:0] ad);
      bus(1'b0, ad, 32'h0);
   endtask
   // waits for one timer's done; n keeps counting from the common start
   task automatic wt(input int k);
      while (n < 13000 && td[k] !== 1'b1) begin @(posedge ref_clk); n++; end
      if (n >= 13000) begin num_errors++; stop_test(); end
   endtask
   always @(posedge ref_clk) begin
      if (cp && !cp_q) edges++;
      cp_q <= cp;
   end
   initial begin
      {hsel, hwrite, run, htrans, haddr, hwdata} = '0;
      hsize = 3'h2; rst_n = 1'b0; r = 16'h0017; edges = 0;
      repeat (12) @(posedge ref_clk);
      rst_n <= 1'b1;
      for (int i = 0; i < 6; i++) begin
         r = lfsr(lfsr(r)); a = (i == 0) ? 16'h0 : r; b = (i < 2) ? a : ~r;
         bus(1'b1, ladder_pkg::A_OPA, {16'h0, a});
         bus(1'b1, ladder_pkg::A_OPB, {16'h0, b});
         op(3'h1, ladder_pkg::OP_MOV); rd(ladder_pkg::A_RES);
         chk("mov", {16'h0, a}, q);
         rd(ladder_pkg::A_FLAGS); chk("mov_eq", a == 0, q[14]);
         op(3'h1, ladder_pkg::OP_MVN); rd(ladder_pkg::A_RES);
         chk("mvn", {16'h0, ~a}, q);
         op(3'h1, ladder_pkg::OP_AND); rd(ladder_pkg::A_RES);
         chk("and", {16'h0, a & b}, q);
         op(3'h1, ladder_pkg::OP_OR); rd(ladder_pkg::A_RES);
         chk("or", {16'h0, a | b}, q);
         op(3'h1, ladder_pkg::OP_CMP); rd(ladder_pkg::A_FLAGS);
         chk("cmp", {a > b, a == b, a < b}, q[15:13]);
      end
      $display("test word ops done");
      bus(1'b1, ladder_pkg::A_FLAGS, 32'h1000); op(3'h1, ladder_pkg::OP_CLC);
      rd(ladder_pkg::A_FLAGS); chk("clc", 1'b0, q[12]);
      bus(1'b1, ladder_pkg::A_OPA, 32'h0999);
      bus(1'b1, ladder_pkg::A_OPB, 32'h0001);
      op(3'h1, ladder_pkg::OP_ADD); rd(ladder_pkg::A_RES);
      chk("add", 32'h1000, q);
      op(3'h1, ladder_pkg::OP_SUB); rd(ladder_pkg::A_RES);
      chk("sub", 32'h0998, q);
      bus(1'b1, ladder_pkg::A_OPA, 32'h0000);
      op(3'h1, ladder_pkg::OP_SUB); rd(ladder_pkg::A_FLAGS);
      chk("borrow", 1'b1, q[12]);
      bus(1'b1, ladder_pkg::A_OPA, 32'h00A0);
      op(3'h1, ladder_pkg::OP_ADD); rd(ladder_pkg::A_FLAGS);
      chk("bad_bcd", 1'b1, q[11]);
      rd(ladder_pkg::A_RES); chk("no_write", 32'h9999, q);
      op(3'h1, ladder_pkg::OP_MOV); rd(ladder_pkg::A_RES);
      chk("er_skip", 32'h9999, q);
      op(3'h0, ladder_pkg::OP_END);
      $display("test decimal done");
      // size 1 and N=1; pairs 10..20 and 30..40, data 35 hits pair 1
      for (int i = 0; i < 5; i++)
         bus(1'b1, 8'(8'h40 + 4 * i), (i == 0) ? 32'h1 : 32'(16 * i));
      bus(1'b1, ladder_pkg::A_OPA, 32'h0035);
      op(3'h1, ladder_pkg::OP_DRUM); rd(ladder_pkg::A_RES);
      chk("drum", 32'h0, q);
      op(3'h1, ladder_pkg::OP_BCMP); rd(ladder_pkg::A_RES);
      chk("bcmp", 32'h2, q);
      op(3'h1, ladder_pkg::OP_KEEP); op(3'h0, ladder_pkg::OP_KEEP);
      chk("keep_hold", 1'b1, kb);
      op(3'h2, ladder_pkg::OP_KEEP); op(3'h0, ladder_pkg::OP_KEEP);
      chk("keep_clr", 1'b0, kb);
      op(3'h3, ladder_pkg::OP_SFT); op(3'h1, ladder_pkg::OP_SFT);
      op(3'h2, ladder_pkg::OP_SFT); rd(ladder_pkg::A_SHIFT);
      chk("shift", 32'h2, q);
      op(3'h4, ladder_pkg::OP_SFT); rd(ladder_pkg::A_SHIFT);
      chk("shift_clr", 32'h0, q);
      $display("test table and shift done");
      bus(1'b1, ladder_pkg::A_CNT_PRE, 32'h0003);
      bus(1'b1, ladder_pkg::A_CCTL, 32'h0001);
      edges = 0; run <= 1'b1;
      for (n = 0; n < 200 && cd !== 1'b1; n++) @(posedge ref_clk);
      if (n >= 200) begin num_errors++; stop_test(); end
      run <= 1'b0;
      chk("cnt_edges", 32'h3, edges);
      rd(ladder_pkg::A_CNT_PV); chk("cnt_pv", 32'h0, q);
      op(3'h0, ladder_pkg::OP_END); @(negedge ref_clk);
      chk("cnt_done", 1'b0, cd);
      @(posedge ref_clk); edges = 0; run <= 1'b1;
      repeat (6) @(posedge ref_clk);
      run <= 1'b0;
      rd(ladder_pkg::A_CNT_PV); chk("cnt_part", edges, q);
      bus(1'b1, ladder_pkg::A_CCTL, 32'h0003);
      rd(ladder_pkg::A_CNT_PV); chk("cnt_held", 32'h0, q);
      bus(1'b1, ladder_pkg::A_FINE_PRE, 32'h0002);
      bus(1'b1, ladder_pkg::A_MS_PRE, 32'h0002);
      // all five start together; time bases run free, so the first
      // step is partial and each done lands within one step of its span
      bus(1'b1, ladder_pkg::A_TCTL, 32'h011F);
      n = 0;
      wt(1); chk("ms_time", 1'b1, n inside {[7:10]});
      wt(0); chk("fine_time", 1'b1, n inside {[43:82]});
      wt(2); chk("panel_time", 1'b1, n inside {[1603:2002]});
      wt(3); chk("one_time", 1'b1, n inside {[3603:4002]});
      wt(4); chk("two_time", 1'b1, n inside {[8003:12002]});
      chk("all_done", 32'h1F, td);
      bus(1'b1, ladder_pkg::A_TCTL, 32'h0000);
      repeat (2) @(negedge ref_clk);
      chk("tclr", 32'h0, td);
      $display("test timers done");
      stop_test();
   end
endmodule
`default_nettype wire
